/* File: option_regs_pkg.sv */
package option_regs_pkg;

    // Register byte addresses
    localparam logic [15:0] ADDR_OPTION_TWO = 16'h001E;
    localparam logic [15:0] ADDR_OPTION_ONE = 16'h001F;

    // Field positions in option_register_two
    localparam int BIT_EXT_CLOCK_ENABLE    = 0;
    localparam int BIT_EXT_CRYSTAL_ENABLE  = 1;
    localparam int BIT_SLOW_CRYSTAL_SELECT = 2;
    localparam int BIT_OSC_RUN_IN_STOP     = 3;
    localparam int BIT_SERIAL_CLOCK_SOURCE = 4;

    // Field positions in option_register_one
    localparam int BIT_WATCHDOG_OFF              = 0;
    localparam int BIT_STOP_ALLOW                = 1;
    localparam int BIT_SHORT_STOP_RECOVERY       = 2;
    localparam int BIT_VOLTAGE_MODE_SELECT       = 3;
    localparam int BIT_VOLTAGE_MONITOR_POWER_OFF = 4;
    localparam int BIT_VOLTAGE_MONITOR_RESET_OFF = 5;
    localparam int BIT_VOLTAGE_MONITOR_IN_STOP   = 6;
    localparam int BIT_WATCHDOG_RATE_SELECT      = 7;

    // Values after reset
    localparam logic [7:0] RESET_OPTION_ONE = 8'h00;
    localparam logic [7:0] RESET_OPTION_TWO = 8'h00;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;

    // Cycle counts, in oscillator clock cycles
    localparam logic [12:0] STAB_CYCLES_CRYSTAL   = 13'h1000;
    localparam logic [12:0] STAB_CYCLES_EXTERNAL  = 13'h0010;
    localparam logic [12:0] STOP_RECOVERY_SHORT   = 13'h0020;
    localparam logic [12:0] STOP_RECOVERY_LONG    = 13'h1000;
    localparam logic [17:0] WATCHDOG_CYCLES_SHORT = 18'h0_1FF0;
    localparam logic [17:0] WATCHDOG_CYCLES_LONG  = 18'h3_FFF0;

    typedef enum logic [1:0] {
        CPU_RUNNING,
        CPU_STOPPED,
        CPU_RECOVERING
    } stop_state_e;

endpackage

/* File: write_once_option_registers.sv */
`timescale 1ns/1ps
`default_nettype none

module write_once_option_registers #(
    parameter bit         MASK_PROGRAMMED = 1'b0,  // Options fixed at fabrication
    parameter logic [7:0] MASK_OPTION_ONE = 8'h00, // Fixed option_register_one
    parameter logic [7:0] MASK_OPTION_TWO = 8'h00  // Fixed option_register_two
) (
    input  wire logic        clock_i,                  // System clock
    input  wire logic        nrst_i,                   // Any reset, sync, low
    input  wire logic        power_on_nrst_i,          // Power-on reset, sync, low
    input  wire logic [15:0] addr_i,                   // Register address
    input  wire logic [7:0]  wdata_i,                  // Write data
    input  wire logic        wr_i,                     // Write strobe
    input  wire logic        rd_i,                     // Read strobe
    output logic      [7:0]  rdata_o,                  // Read data, cycle after read
    input  wire logic        stop_instr_i,             // CPU decodes stop instruction
    input  wire logic        wake_i,                   // Wake-up event while stopped
    input  wire logic        monitor_reset_req_i,      // Low-voltage monitor reset request
    output logic             osc_pin_in_clock_o,       // First pin is clock input
    output logic             osc_pin_out_crystal_o,    // Second pin is crystal connection
    output logic             port_b_line_six_gpio_o,   // First pin is general I/O
    output logic             port_b_line_seven_gpio_o, // Second pin is general I/O
    output logic             slow_crystal_o,           // Slow crystal operation
    output logic             monitor_expect_low_o,     // Monitor expects below base frequency
    output logic             monitor_crystal_range_o,  // Monitor expects crystal ranges
    output logic      [12:0] stab_timeout_cycles_o,    // Stabilization divider timeout
    output logic             gen_clocks_halt_o,        // Hold both generated clocks low
    output logic             serial_clock_from_bus_o,  // Serial clock from bus clock
    output logic      [17:0] watchdog_timeout_o,       // Watchdog timeout in cycles
    output logic             watchdog_enable_o,        // Watchdog runs
    output logic             monitor_power_on_o,       // Monitor powered
    output logic             monitor_run_in_stop_o,    // Monitor kept running in stop
    output logic             monitor_reset_o,          // Reset passed to reset logic
    output logic             monitor_5v_mode_o,        // Monitor in 5 V mode
    output logic             stop_mode_o,              // CPU in stop or recovering
    output logic             stop_release_o,           // Pulse: CPU leaves stop
    output logic             illegal_opcode_reset_o    // Pulse: disallowed stop executed
);

    typedef struct packed {
        logic [7:0]                      opt_one;
        logic [7:0]                      opt_two;
        logic                            written_one;
        logic                            written_two;
        logic [7:0]                      rdata;
        option_regs_pkg::stop_state_e    stop_state;
        logic [12:0]                     recover_cnt;
        logic                            release_pulse;
        logic                            illegal_pulse;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic [7:0] eff_one;
    logic [7:0] eff_two;
    logic       ext_clk;
    logic       ext_xtal;
    logic       stop_allow;
    logic       hit_one;
    logic       hit_two;

    // The mask variant ignores the latches entirely, so the stored copy can never leak out
    assign eff_one = MASK_PROGRAMMED ? MASK_OPTION_ONE : state_reg.opt_one;
    assign eff_two = MASK_PROGRAMMED ? MASK_OPTION_TWO : state_reg.opt_two;

    assign hit_one = (addr_i == option_regs_pkg::ADDR_OPTION_ONE);
    assign hit_two = (addr_i == option_regs_pkg::ADDR_OPTION_TWO);

    assign ext_clk    = eff_two[option_regs_pkg::BIT_EXT_CLOCK_ENABLE];
    assign ext_xtal   = eff_two[option_regs_pkg::BIT_EXT_CRYSTAL_ENABLE];
    assign stop_allow = eff_one[option_regs_pkg::BIT_STOP_ALLOW];

    always_comb begin
        state_next = state_reg;
        state_next.release_pulse = 1'b0;
        state_next.illegal_pulse = 1'b0;
        state_next.rdata = option_regs_pkg::READ_UNMAPPED;

        // Register writes, first one per reset wins
        if (wr_i && hit_one && !state_reg.written_one && !MASK_PROGRAMMED) begin
            state_next.opt_one = wdata_i;
            state_next.written_one = 1'b1;
        end
        if (wr_i && hit_two && !state_reg.written_two && !MASK_PROGRAMMED) begin
            state_next.opt_two = wdata_i;
            state_next.written_two = 1'b1;
        end
        // Later writes fall through the guards above and leave no trace

        if (rd_i) begin
            if (hit_one) begin
                state_next.rdata = eff_one;
            end else if (hit_two) begin
                state_next.rdata = eff_two;
            end
        end

        // Stop sequencing
        case (state_reg.stop_state)
            option_regs_pkg::CPU_RUNNING: begin
                if (stop_instr_i) begin
                    if (stop_allow) begin
                        state_next.stop_state = option_regs_pkg::CPU_STOPPED;
                    end else begin
                        state_next.illegal_pulse = 1'b1;
                    end
                end
            end
            option_regs_pkg::CPU_STOPPED: begin
                if (monitor_reset_req_i
                    && !eff_one[option_regs_pkg::BIT_VOLTAGE_MONITOR_RESET_OFF]) begin
                    state_next.recover_cnt = option_regs_pkg::STOP_RECOVERY_LONG;
                    state_next.stop_state = option_regs_pkg::CPU_RECOVERING;
                end else if (wake_i) begin
                    // Short recovery is only safe if the oscillator kept running
                    state_next.recover_cnt = eff_one[option_regs_pkg::BIT_SHORT_STOP_RECOVERY]
                        ? option_regs_pkg::STOP_RECOVERY_SHORT
                        : option_regs_pkg::STOP_RECOVERY_LONG;
                    state_next.stop_state = option_regs_pkg::CPU_RECOVERING;
                end
            end
            option_regs_pkg::CPU_RECOVERING: begin
                if (state_reg.recover_cnt <= 13'h0001) begin
                    state_next.recover_cnt = 13'h0000;
                    state_next.release_pulse = 1'b1;
                    state_next.stop_state = option_regs_pkg::CPU_RUNNING;
                end else begin
                    state_next.recover_cnt = state_reg.recover_cnt - 13'h0001;
                end
            end
            default: begin
                state_next.stop_state = option_regs_pkg::CPU_RUNNING;
            end
        endcase

        // Any reset: everything clears but the voltage mode bit, which only power-on reset clears
        if (!nrst_i) begin
            state_next.opt_one = (option_regs_pkg::RESET_OPTION_ONE
                & ~(8'h01 << option_regs_pkg::BIT_VOLTAGE_MODE_SELECT))
                | (state_reg.opt_one
                & (8'h01 << option_regs_pkg::BIT_VOLTAGE_MODE_SELECT));
            state_next.opt_two = option_regs_pkg::RESET_OPTION_TWO;
            state_next.written_one = 1'b0;
            state_next.written_two = 1'b0;
            state_next.rdata = option_regs_pkg::READ_UNMAPPED;
            state_next.stop_state = option_regs_pkg::CPU_RUNNING;
            state_next.recover_cnt = 13'h0000;
            state_next.release_pulse = 1'b0;
            state_next.illegal_pulse = 1'b0;
        end
        if (!power_on_nrst_i) begin
            state_next.opt_one[option_regs_pkg::BIT_VOLTAGE_MODE_SELECT] = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        state_reg <= state_next;
    end

    assign rdata_o = state_reg.rdata;

    // Pin function select
    assign osc_pin_in_clock_o       = ext_clk;
    assign osc_pin_out_crystal_o    = ext_clk & ext_xtal;
    assign port_b_line_six_gpio_o   = ~ext_clk;
    assign port_b_line_seven_gpio_o = ~(ext_clk & ext_xtal);

    // Clock generator and clock monitor
    assign slow_crystal_o          = eff_two[option_regs_pkg::BIT_SLOW_CRYSTAL_SELECT];
    assign monitor_expect_low_o    = eff_two[option_regs_pkg::BIT_SLOW_CRYSTAL_SELECT];
    assign monitor_crystal_range_o = ext_xtal;
    assign stab_timeout_cycles_o   = ext_xtal ? option_regs_pkg::STAB_CYCLES_CRYSTAL
                                              : option_regs_pkg::STAB_CYCLES_EXTERNAL;
    // Recovery keeps clocks up: the countdown runs on them
    assign gen_clocks_halt_o = (state_reg.stop_state == option_regs_pkg::CPU_STOPPED)
                             & ~eff_two[option_regs_pkg::BIT_OSC_RUN_IN_STOP];
    assign serial_clock_from_bus_o = eff_two[option_regs_pkg::BIT_SERIAL_CLOCK_SOURCE];

    // Watchdog
    assign watchdog_timeout_o = eff_one[option_regs_pkg::BIT_WATCHDOG_RATE_SELECT]
        ? option_regs_pkg::WATCHDOG_CYCLES_SHORT
        : option_regs_pkg::WATCHDOG_CYCLES_LONG;
    assign watchdog_enable_o = ~eff_one[option_regs_pkg::BIT_WATCHDOG_OFF];

    // Low-voltage monitor
    assign monitor_power_on_o = ~eff_one[option_regs_pkg::BIT_VOLTAGE_MONITOR_POWER_OFF];
    assign monitor_run_in_stop_o = eff_one[option_regs_pkg::BIT_VOLTAGE_MONITOR_IN_STOP]
        & ~eff_one[option_regs_pkg::BIT_VOLTAGE_MONITOR_POWER_OFF];
    assign monitor_reset_o = monitor_reset_req_i
        & ~eff_one[option_regs_pkg::BIT_VOLTAGE_MONITOR_RESET_OFF];
    assign monitor_5v_mode_o = eff_one[option_regs_pkg::BIT_VOLTAGE_MODE_SELECT];

    // CPU stop control
    assign stop_mode_o            = (state_reg.stop_state != option_regs_pkg::CPU_RUNNING);
    assign stop_release_o         = state_reg.release_pulse;
    assign illegal_opcode_reset_o = state_reg.illegal_pulse;

endmodule

`default_nettype wire

/* File: option_regs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module option_regs_checker (
    input wire logic        clock_i, nrst_i, wr_i, rd_i, stop_instr_i, monitor_reset_req_i,
    input wire logic        osc_pin_in_clock_o, osc_pin_out_crystal_o, slow_crystal_o,
    input wire logic        monitor_expect_low_o, monitor_reset_o, monitor_crystal_range_o,
    input wire logic        monitor_power_on_o, monitor_run_in_stop_o, monitor_5v_mode_o,
    input wire logic        stop_mode_o, illegal_opcode_reset_o, stop_release_o,
    input wire logic [7:0]  rdata_o,
    input wire logic [12:0] stab_timeout_cycles_o,
    input wire logic [17:0] watchdog_timeout_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    read_idle_zero_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    crystal_pins_a: assert property (osc_pin_out_crystal_o |-> osc_pin_in_clock_o)
        else $error("crystal pin without clock pin");
    stab_count_a: assert property (stab_timeout_cycles_o ==
        (monitor_crystal_range_o ? 13'h1000 : 13'h0010)) else $error("bad stabilization count");
    slow_monitor_a: assert property (slow_crystal_o == monitor_expect_low_o)
        else $error("slow crystal and monitor range differ");
    monitor_stop_a: assert property (monitor_run_in_stop_o |-> monitor_power_on_o)
        else $error("monitor in stop while powered down");
    monitor_gate_a: assert property (monitor_reset_o |-> monitor_reset_req_i)
        else $error("monitor reset without request");
    options_hold_a: assert property (!$past(wr_i) && $past(nrst_i) |->
        $stable(watchdog_timeout_o) && $stable(osc_pin_in_clock_o) && $stable(monitor_5v_mode_o))
        else $error("options changed without a write");
    stop_outcome_a: assert property (stop_instr_i && !stop_mode_o |=>
        stop_mode_o != illegal_opcode_reset_o) else $error("stop neither taken nor refused");
    cover property (wr_i ##1 !wr_i);
    cover property (stop_release_o);
    cover property (illegal_opcode_reset_o);
endmodule
bind write_once_option_registers option_regs_checker i_checker (.*);
`default_nettype wire

/* File: write_once_option_registers_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module write_once_option_registers_tb;
    logic        clock_i, nrst_i, power_on_nrst_i, wr_i, rd_i, stop_instr_i, wake_i;
    logic        monitor_reset_req_i, osc_pin_in_clock_o, osc_pin_out_crystal_o, slow_crystal_o;
    logic        port_b_line_six_gpio_o, port_b_line_seven_gpio_o, monitor_expect_low_o;
    logic        monitor_crystal_range_o, gen_clocks_halt_o, serial_clock_from_bus_o;
    logic        watchdog_enable_o, monitor_power_on_o, monitor_run_in_stop_o, monitor_reset_o;
    logic        monitor_5v_mode_o, stop_mode_o, stop_release_o, illegal_opcode_reset_o;
    logic [15:0] addr_i;
    logic [7:0]  wdata_i, rdata_o;
    logic [12:0] stab_timeout_cycles_o;
    logic [17:0] watchdog_timeout_o;
    logic [7:0]  mask_rdata;
    // Fixed values for the mask-programmed copy; any distinct pattern will do
    localparam logic [7:0] MASK_ONE = 8'h5A;
    localparam logic [7:0] MASK_TWO = 8'hA5;
    int          mismatches = 0;
    int          n_compared = 0;
    write_once_option_registers i_dut (.*);
    // Copy with options fixed at fabrication; shares the bus and must ignore writes
    write_once_option_registers #(
        .MASK_PROGRAMMED (1'b1),
        .MASK_OPTION_ONE (MASK_ONE),
        .MASK_OPTION_TWO (MASK_TWO)
    ) i_dut_mask (
        .clock_i, .nrst_i, .power_on_nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o(mask_rdata), .stop_instr_i, .wake_i, .monitor_reset_req_i,
        .osc_pin_in_clock_o(), .osc_pin_out_crystal_o(), .port_b_line_six_gpio_o(),
        .port_b_line_seven_gpio_o(), .slow_crystal_o(), .monitor_expect_low_o(),
        .monitor_crystal_range_o(), .stab_timeout_cycles_o(), .gen_clocks_halt_o(),
        .serial_clock_from_bus_o(), .watchdog_timeout_o(), .watchdog_enable_o(),
        .monitor_power_on_o(), .monitor_run_in_stop_o(), .monitor_reset_o(),
        .monitor_5v_mode_o(), .stop_mode_o(), .stop_release_o(), .illegal_opcode_reset_o()
    );
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) $display("BAD at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp) mismatches++;
    endtask
    // On a read, d is the value expected in the slot after the strobe
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        logic [7:0] fixed;
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        {wr_i, rd_i} <= {w, !w};
        @(posedge clock_i);
        {wr_i, rd_i} <= 2'b00;
        #1;
        if (!w) begin
            fixed = (a == 16'h001F) ? MASK_ONE : (a == 16'h001E) ? MASK_TWO : 8'h00;
            chk(rdata_o, d);
            chk(mask_rdata, fixed);
        end
    endtask
    // Wake or monitor request is raised at the edge that takes stop, so it lands while stopped
    task automatic stop_run(input logic by_monitor, input logic [17:0] exp_n,
                            input logic exp_halt);
        int n;
        @(posedge clock_i);
        stop_instr_i <= 1'b1;
        @(posedge clock_i);
        stop_instr_i <= 1'b0;
        {wake_i, monitor_reset_req_i} <= {!by_monitor, by_monitor};
        #1 chk(stop_mode_o, 1'b1);
        chk(gen_clocks_halt_o, exp_halt);
        chk(monitor_reset_o, by_monitor);
        @(posedge clock_i);
        {wake_i, monitor_reset_req_i} <= 2'b00;
        n = 0;
        while (stop_release_o !== 1'b1 && n < 5000) begin
            @(posedge clock_i);
            #1 n++;
        end
        chk(18'(n), exp_n);
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        results();
    end
    initial begin
        {nrst_i, power_on_nrst_i, wr_i, rd_i, stop_instr_i, wake_i} <= '0;
        {monitor_reset_req_i, addr_i, wdata_i} <= '0;
        repeat (5) @(posedge clock_i);
        {nrst_i, power_on_nrst_i} <= 2'b11;
        bus(1'b0, 16'h001F, 8'h00);
        chk(watchdog_timeout_o, 18'h3_FFF0);
        bus(1'b1, 16'h001F, 8'hCE);
        // Oscillator kept running in stop, so short recovery is a safe choice here
        bus(1'b1, 16'h001E, 8'hEB);
        bus(1'b1, 16'h001F, 8'h11);
        bus(1'b1, 16'h0020, 8'hFF);
        bus(1'b0, 16'h001F, 8'hCE);
        bus(1'b0, 16'h001E, 8'hEB);
        bus(1'b0, 16'h0020, 8'h00);
        chk(watchdog_timeout_o, 18'h0_1FF0);
        chk(port_b_line_seven_gpio_o, 1'b0);
        chk(osc_pin_out_crystal_o, 1'b1);
        chk(stab_timeout_cycles_o, option_regs_pkg::STAB_CYCLES_CRYSTAL);
        chk(monitor_crystal_range_o, 1'b1);
        chk(monitor_run_in_stop_o, 1'b1);
        chk(monitor_5v_mode_o, 1'b1);
        chk(slow_crystal_o, 1'b0);
        stop_run(1'b0, option_regs_pkg::STOP_RECOVERY_SHORT, 1'b0);
        stop_run(1'b1, option_regs_pkg::STOP_RECOVERY_LONG, 1'b0);
        // Plain reset keeps the voltage mode bit
        @(posedge clock_i);
        nrst_i <= 1'b0;
        @(posedge clock_i);
        nrst_i <= 1'b1;
        bus(1'b0, 16'h001F, 8'h08);
        bus(1'b1, 16'h001F, 8'h3B);
        bus(1'b1, 16'h001E, 8'h14);
        chk(watchdog_enable_o, 1'b0);
        chk(monitor_power_on_o, 1'b0);
        chk(port_b_line_six_gpio_o, 1'b1);
        chk(osc_pin_in_clock_o, 1'b0);
        chk(serial_clock_from_bus_o, 1'b1);
        chk(monitor_expect_low_o, 1'b1);
        chk(stab_timeout_cycles_o, option_regs_pkg::STAB_CYCLES_EXTERNAL);
        chk(monitor_crystal_range_o, 1'b0);
        stop_run(1'b0, option_regs_pkg::STOP_RECOVERY_LONG, 1'b1);
        // Power-on reset clears the voltage mode bit too and leaves stop refused
        @(posedge clock_i);
        {nrst_i, power_on_nrst_i} <= 2'b00;
        @(posedge clock_i);
        {nrst_i, power_on_nrst_i} <= 2'b11;
        bus(1'b0, 16'h001F, 8'h00);
        @(posedge clock_i);
        stop_instr_i <= 1'b1;
        @(posedge clock_i);
        stop_instr_i <= 1'b0;
        #1 chk(illegal_opcode_reset_o, 1'b1);
        results();
    end
endmodule
`default_nettype wire
